// ===== sac_pkg.sv
// Constants and types shared by the converter control logic.
// Overview of operation
// - High result register holds result bits nine..two.
// - Low register holds bits one..zero, rest zero.
// - Input above reference saturates result to full scale.
// - Input below reference gives zero result.
// - Converter-on bit starts continuous repeated conversion.
// - Clearing converter-on stops conversion in progress.
// - Conversion end stores result, sets done flag.
// - Done flag clears on high read or write.
// - Control bits writable, done flag read only.
// - Channel change aborts, clears done, restarts conversion.
// - Four-bit channel field selects inputs 0 to 15.
// - Slow and speed bits choose converter clock divider.
// - Low register read freezes both result registers.
// - Freeze released by high read or converter off.
// - Frozen registers hold new results back until released.
// - Wait mode leaves converter operation unchanged.
// - Reset clears control and both result registers.
package sac_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned RES_W         = 10;
    localparam int unsigned CH_W          = 4;
    localparam logic [7:0]  OFS_CSR       = 8'h45;
    localparam logic [7:0]  OFS_RES_HIGH  = 8'h46;
    localparam logic [7:0]  OFS_RES_LOW   = 8'h47;
    localparam logic [7:0]  CSR_RESET     = 8'h00;
    localparam logic [7:0]  RES_RESET     = 8'h00;
    localparam int unsigned BIT_DONE      = 7;
    localparam int unsigned BIT_SPEED     = 6;
    localparam int unsigned BIT_ON        = 5;
    localparam int unsigned BIT_SLOW      = 4;
    localparam logic [9:0]  RES_FULL      = 10'h3FF;
    localparam logic [9:0]  RES_ZERO      = 10'h000;
    // Conversion takes one sample step plus one step per result bit.
    localparam logic [3:0]  CONV_STEPS    = 4'hB;
    // Divider terminal counts: divide by one, two and four.
    localparam logic [1:0]  DIV1_LAST     = 2'h0;
    localparam logic [1:0]  DIV2_LAST     = 2'h1;
    localparam logic [1:0]  DIV4_LAST     = 2'h3;
    typedef enum logic [1:0] {
        SAC_OFF,
        SAC_SAMPLE,
        SAC_CONVERT
    } sac_state_t;
endpackage

// ===== sac_adc_ctrl.sv
// Control, clock selection and result handling for a 10-bit SAR converter.
`timescale 1ns/1ps
module sac_adc_ctrl (
    // Clock, reset and enable
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        clk_en_in,
    // Wishbone classic slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [0:0]  wb_sel_in,
    input  wire logic [7:0]  wb_dat_in,
    output logic      [7:0]  wb_dat_out,
    output logic             wb_ack_out,
    // Analog front end: asynchronous comparator and range detector inputs, registered control outputs
    input  wire logic        cmp_high_in,
    input  wire logic        above_ref_in,
    input  wire logic        below_ref_in,
    output logic      [3:0]  input_select_out,
    output logic             converter_on_out,
    output logic             sample_out,
    output logic      [9:0]  trial_code_out
);
    logic [7:0]           conv_control_status;
    logic [9:0]           result;
    logic                 frozen;
    logic [9:0]           pending;
    logic                 pending_valid;
    sac_pkg::sac_state_t  state;
    logic [3:0]           step;
    logic [9:0]           sar;
    logic [1:0]           div_cnt;
    logic [1:0]           div_last;
    logic                 adc_tick;
    logic [2:0]           cmp_sync;
    logic [2:0]           above_sync;
    logic [2:0]           below_sync;
    logic                 bus_req;
    logic                 wr_csr;
    logic                 rd_high;
    logic                 rd_low;
    logic                 ch_change;
    logic                 conv_done;
    logic [9:0]           final_code;
    logic [9:0]           trial_bit;

    assign bus_req   = wb_cyc_in && wb_stb_in && !wb_ack_out && clk_en_in;
    assign wr_csr    = bus_req && wb_we_in && wb_sel_in[0]
                       && wb_adr_in == sac_pkg::OFS_CSR;
    assign rd_high   = bus_req && !wb_we_in
                       && wb_adr_in == sac_pkg::OFS_RES_HIGH;
    assign rd_low    = bus_req && !wb_we_in
                       && wb_adr_in == sac_pkg::OFS_RES_LOW;
    assign ch_change = wr_csr && wb_dat_in[3:0] != conv_control_status[3:0];

    // Three-stage synchronisers; only the third stage feeds logic.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cmp_sync   <= 3'h0;
            above_sync <= 3'h0;
            below_sync <= 3'h0;
        end else if (clk_en_in) begin
            cmp_sync   <= {cmp_sync[1], cmp_sync[0], cmp_high_in};
            above_sync <= {above_sync[1], above_sync[0], above_ref_in};
            below_sync <= {below_sync[1], below_sync[0], below_ref_in};
        end
    end

    // Speed/slow: 00 and 11 give /2, speed alone /1, slow alone /4.
    // The /1 setting is only legal with a CPU clock at or below 4 MHz.
    always_comb begin
        unique case ({conv_control_status[sac_pkg::BIT_SLOW],
                      conv_control_status[sac_pkg::BIT_SPEED]})
            2'h1:    div_last = sac_pkg::DIV1_LAST;
            2'h2:    div_last = sac_pkg::DIV4_LAST;
            default: div_last = sac_pkg::DIV2_LAST;
        endcase
    end
    assign adc_tick = div_cnt == div_last;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            div_cnt <= 2'h0;
        end else if (clk_en_in) begin
            // The divider runs whenever the converter is on, so that the
            // first tick after power-up also arrives in the slower settings.
            if (!conv_control_status[sac_pkg::BIT_ON] || adc_tick || ch_change)
                div_cnt <= 2'h0;
            else
                div_cnt <= div_cnt + 2'h1;
        end
    end

    assign trial_bit = 10'h200 >> (step - 4'h1);
    assign final_code = above_sync[2] ? sac_pkg::RES_FULL :
                        below_sync[2] ? sac_pkg::RES_ZERO :
                        (cmp_sync[2] ? sar : (sar & ~trial_bit));
    assign conv_done = state == sac_pkg::SAC_CONVERT && adc_tick
                       && step == sac_pkg::CONV_STEPS - 4'h1 && !ch_change;

    // Sequencer. Wait mode needs no handling here; halt is modelled by
    // the clock enable, which freezes all state.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state <= sac_pkg::SAC_OFF;
            step  <= 4'h0;
            sar   <= 10'h000;
        end else if (clk_en_in) begin
            if (!conv_control_status[sac_pkg::BIT_ON]) begin
                state <= sac_pkg::SAC_OFF;
                step  <= 4'h0;
            end else if (ch_change) begin
                state <= sac_pkg::SAC_SAMPLE;
                step  <= 4'h0;
            end else if (adc_tick) begin
                unique case (state)
                    sac_pkg::SAC_OFF: begin
                        state <= sac_pkg::SAC_SAMPLE;
                        step  <= 4'h0;
                    end
                    sac_pkg::SAC_SAMPLE: begin
                        state <= sac_pkg::SAC_CONVERT;
                        step  <= 4'h1;
                        sar   <= 10'h200;
                    end
                    sac_pkg::SAC_CONVERT: begin
                        if (step == sac_pkg::CONV_STEPS - 4'h1) begin
                            state <= sac_pkg::SAC_SAMPLE;
                            step  <= 4'h0;
                        end else begin
                            sar  <= (cmp_sync[2] ? sar : (sar & ~trial_bit))
                                    | (trial_bit >> 1);
                            step <= step + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Control/status register; done flag is hardware owned.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            conv_control_status <= sac_pkg::CSR_RESET;
        end else if (clk_en_in) begin
            if (wr_csr)
                conv_control_status[6:0] <= wb_dat_in[6:0];
            // Set wins over clear when both land in one cycle.
            if (conv_done)
                conv_control_status[sac_pkg::BIT_DONE] <= 1'b1;
            else if (wr_csr || rd_high || ch_change)
                conv_control_status[sac_pkg::BIT_DONE] <= 1'b0;
        end
    end

    // Result registers with read lock. A result that completes while
    // locked is parked and lands once the high byte has been read or the converter is switched off.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            result        <= {sac_pkg::RES_RESET, 2'h0};
            frozen        <= 1'b0;
            pending       <= 10'h000;
            pending_valid <= 1'b0;
        end else if (clk_en_in) begin
            if (rd_low)
                frozen <= 1'b1;
            else if (rd_high || !conv_control_status[sac_pkg::BIT_ON])
                frozen <= 1'b0;
            if (conv_done && (frozen || rd_low)) begin
                pending       <= final_code;
                pending_valid <= 1'b1;
            end else if (conv_done) begin
                result        <= final_code;
                pending_valid <= 1'b0;
            end else if (pending_valid && !frozen) begin
                result        <= pending;
                pending_valid <= 1'b0;
            end
        end
    end

    // Single-cycle Wishbone answer; unmapped addresses read as zero.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 8'h00;
        end else if (clk_en_in) begin
            wb_ack_out <= bus_req;
            if (bus_req && !wb_we_in) begin
                unique case (wb_adr_in)
                    sac_pkg::OFS_CSR:      wb_dat_out <= conv_control_status;
                    sac_pkg::OFS_RES_HIGH: wb_dat_out <= result[9:2];
                    sac_pkg::OFS_RES_LOW:
                        wb_dat_out <= {6'h00, result[1:0]};
                    default:               wb_dat_out <= 8'h00;
                endcase
            end else begin
                wb_dat_out <= 8'h00;
            end
        end
    end

    // Analog-facing controls, registered.
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            input_select_out <= 4'h0;
            converter_on_out <= 1'b0;
            sample_out       <= 1'b0;
            trial_code_out   <= 10'h000;
        end else if (clk_en_in) begin
            input_select_out <= conv_control_status[3:0];
            converter_on_out <= conv_control_status[sac_pkg::BIT_ON];
            sample_out       <= state == sac_pkg::SAC_SAMPLE;
            trial_code_out   <= sar;
        end
    end
endmodule // sac_adc_ctrl

// ===== sac_adc_ctrl_monitor.sv
// Bus and control assertions for the converter control block.
`timescale 1ns/1ps
module sac_adc_ctrl_monitor (
    // Clock and reset
    input wire logic       clk_sys_in,
    input wire logic       rst_n_in,
    input wire logic       clk_en_in,
    // Bus
    input wire logic       wb_cyc_in,
    input wire logic       wb_stb_in,
    input wire logic       wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [0:0] wb_sel_in,
    input wire logic [7:0] wb_dat_in,
    input wire logic [7:0] wb_dat_out,
    input wire logic       wb_ack_out,
    // Converter control
    input wire logic [3:0] input_select_out,
    input wire logic       converter_on_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic       csr_wr;
    logic [3:0] chan_q;
    assign csr_wr = wb_ack_out && wb_we_in && wb_adr_in == 8'h45
                    && wb_sel_in[0];
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) chan_q <= 4'h0;
        else if (csr_wr) chan_q <= wb_dat_in[3:0];
    end
    AST_ACK_AFTER_TAKE: assert property (wb_cyc_in && wb_stb_in && clk_en_in
        && !wb_ack_out |=> wb_ack_out) else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_out && clk_en_in |=> !wb_ack_out)
        else $error("ack too long");
    AST_IDLE_DATA: assert property (!wb_ack_out |-> wb_dat_out == 8'h00)
        else $error("read data outside ack");
    AST_UNMAPPED_ZERO: assert property (wb_ack_out && !wb_we_in &&
        (wb_adr_in < 8'h45 || wb_adr_in > 8'h47) |-> wb_dat_out == 8'h00)
        else $error("unmapped read not zero");
    AST_LOW_UPPER_ZERO: assert property (wb_ack_out && !wb_we_in &&
        wb_adr_in == 8'h47 |-> wb_dat_out[7:2] == 6'h00)
        else $error("low result upper bits set");
    AST_OFF_WRITE: assert property (csr_wr && !wb_dat_in[5]
        |-> ##[0:2] !converter_on_out) else $error("converter stays on");
    AST_ON_WRITE: assert property (csr_wr && wb_dat_in[5]
        |-> ##[0:2] converter_on_out) else $error("converter not on");
    AST_CHANNEL_WRITE: assert property ($past(csr_wr)
        |-> ##[0:1] input_select_out == chan_q) else $error("channel wrong");
    AST_RESET_CLEAR: assert property ($rose(rst_n_in) |->
        !wb_ack_out && !converter_on_out && input_select_out == 4'h0)
        else $error("outputs not cleared by reset");
    COV_LOW_READ: cover property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h47);
    COV_ON: cover property ($rose(converter_on_out));
    COV_CHAN: cover property ($changed(input_select_out) && converter_on_out);
endmodule // sac_adc_ctrl_monitor

// ===== sac_adc_ctrl_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module sac_adc_ctrl_tb;
    logic       clk_sys_in = 1'b0, rst_n_in = 1'b0, ack, on;
    logic       cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic       cmp = 1'b0, above = 1'b0, below = 1'b0;
    logic [7:0] adr = 8'h00, dat = 8'h00, q, d, dat_out;
    logic       en = 1'b1, smp;
    logic [3:0] sel_ch;
    logic [9:0] trial, t;
    // One control value per clock setting, each on a new channel so that
    // every write restarts the conversion.
    logic [7:0] modes [4] = '{8'h27, 8'h68, 8'h39, 8'h7A};
    int         fail_count = 0, n_compared = 0, cycles = 0, seed, ticks;
    always #4 clk_sys_in = ~clk_sys_in;
    sac_adc_ctrl sac_adc_ctrl_i (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(en),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(1'b1), .wb_dat_in(dat),
        .wb_dat_out(dat_out), .wb_ack_out(ack), .cmp_high_in(cmp),
        .above_ref_in(above), .below_ref_in(below),
        .input_select_out(sel_ch), .converter_on_out(on),
        .sample_out(smp), .trial_code_out(trial));
    task automatic check(input string nm, input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // The request rises just after an edge and stands until the edge at
    // which ack is sampled high; read data is taken at that same edge.
    // The leading edge keeps cyc low for a cycle between two calls.
    task automatic bus(input logic w, input logic [7:0] a, v);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= v;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            fail_count++;
        q = dat_out;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    // Converter clock divider that a control value selects.
    function automatic int exp_div(input logic [7:0] m);
        if (m[4] == m[6])
            return 2;
        return m[6] ? 1 : 4;
    endfunction
    // One sampling phase lasts one converter clock, so its width in
    // system clocks shows the divider in use.
    task automatic sample_width;
        int n;
        n = 0;
        ticks = 0;
        while (smp !== 1'b0 && n < 100) begin
            @(posedge clk_sys_in);
            n++;
        end
        while (smp !== 1'b1 && n < 100) begin
            @(posedge clk_sys_in);
            n++;
        end
        while (smp === 1'b1 && n < 100) begin
            @(posedge clk_sys_in);
            n++;
            ticks++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, exp, input string nm);
        bus(1'b0, a, 8'h00);
        check(nm, q, exp);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        q = 8'h00;
        while (q[7] !== 1'b1 && n < 100) begin
            bus(1'b0, 8'h45, 8'h00);
            n++;
        end
        check("done flag", {7'h00, q[7]}, 8'h01);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin fail_count++; final_report; end
    end
    initial begin
        seed = 32'h20b93b86;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int i = 0; i < 4; i++)
            rdc(8'h45 + i[7:0], 8'h00, "reset");
        $display("test reset values done");
        repeat (4) begin
            d = 8'($random(seed)) & 8'hDF;
            bus(1'b1, 8'h45, d | 8'h80);
            rdc(8'h45, d & 8'h5F, "control");
            check("channel", {4'h0, sel_ch}, {4'h0, d[3:0]});
        end
        bus(1'b1, 8'h46, 8'hFF);
        rdc(8'h46, 8'h00, "result read only");
        $display("test register access done");
        cmp <= 1'b1;
        bus(1'b1, 8'h45, 8'h20);
        wait_done;
        rdc(8'h47, 8'h03, "low bits");
        rdc(8'h46, 8'hFF, "high byte");
        rdc(8'h45, 8'h20, "done cleared");
        wait_done;
        rdc(8'h47, 8'h03, "lock low");
        below <= 1'b1;
        repeat (60) @(posedge clk_sys_in);
        rdc(8'h46, 8'hFF, "held high");
        repeat (60) @(posedge clk_sys_in);
        wait_done;
        rdc(8'h47, 8'h00, "below low");
        rdc(8'h46, 8'h00, "below high");
        rdc(8'h46, 8'h00, "high only");
        below <= 1'b0; above <= 1'b1; cmp <= 1'b0;
        repeat (60) @(posedge clk_sys_in);
        wait_done;
        rdc(8'h46, 8'hFF, "above high unlocked");
        rdc(8'h47, 8'h03, "above low");
        rdc(8'h46, 8'hFF, "above high");
        $display("test result handling done");
        above <= 1'b0; cmp <= 1'b1;
        foreach (modes[i]) begin
            wait_done;
            bus(1'b1, 8'h45, modes[i]);
            rdc(8'h45, modes[i], "restart clears done");
            wait_done;
            sample_width;
            check("ticks", 8'(ticks), 8'(exp_div(modes[i])));
            check("first trial", trial[9:2], 8'h80);
            check("first trial low", {6'h00, trial[1:0]}, 8'h00);
            rdc(8'h46, 8'hFF, "mode result");
        end
        $display("test channel and clock modes done");
        en <= 1'b0;
        @(posedge clk_sys_in);
        t = trial;
        repeat (20) @(posedge clk_sys_in);
        check("halt high", trial[9:2], t[9:2]);
        check("halt low", {6'h00, trial[1:0]}, {6'h00, t[1:0]});
        en <= 1'b1;
        // Settling time after wake-up before results are trusted.
        repeat (10) @(posedge clk_sys_in);
        $display("test halt freeze done");
        rdc(8'h47, 8'h03, "lock before off");
        below <= 1'b1;
        bus(1'b1, 8'h45, 8'h07);
        @(posedge clk_sys_in);
        check("converter off", {7'h00, on}, 8'h00);
        bus(1'b1, 8'h45, 8'h27);
        repeat (60) @(posedge clk_sys_in);
        wait_done;
        rdc(8'h46, 8'h00, "unlocked by off");
        $display("test power off unlock done");
        below <= 1'b0;
        repeat (60) @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int i = 0; i < 3; i++)
            rdc(8'h45 + i[7:0], 8'h00, "reset again");
        $display("test second reset done");
        final_report;
    end
endmodule // sac_adc_ctrl_tb
bind sac_adc_ctrl sac_adc_ctrl_monitor sac_adc_ctrl_monitor_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .input_select_out(input_select_out), .converter_on_out(converter_on_out));
